/* core_exec_pkg.sv */
// Shared types and constants for the execute-stage subset
package core_exec_pkg;

    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 8;
    localparam int JUMP_W     = 11;
    localparam int PC_W       = 15;
    localparam int LATCH_LO   = 3;
    localparam int LATCH_HI   = 6;
    localparam int MEM_DEPTH  = 128;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;
    localparam logic [7:0]  ONE_BYTE   = 8'h01;
    localparam logic [14:0] PC_RESET   = 15'h0000;
    localparam logic [6:0]  LATCH_RESET = 7'h00;

    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_CLR_ACC = 3'b001,
        OP_DEC_SKZ = 3'b010,
        OP_INC_SKZ = 3'b011,
        OP_JUMP    = 3'b100,
        OP_OR_LIT  = 3'b101,
        OP_INC_MEM = 3'b110,
        OP_OR_MEM  = 3'b111
    } op_e;

    typedef struct packed {
        op_e         op;
        logic [6:0]  addr;
        logic        dest_mem;
        logic [10:0] imm;
    } instr_s;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_FLUSH = 2'b01
    } state_e;

endpackage

/* core_alu.sv */
// Result arithmetic for the execute subset
`timescale 1ns/1ps
module core_alu
    import core_exec_pkg::*;
(
    input  wire op_e        op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] mem,
    input  wire logic [7:0] lit,
    output logic [7:0]      result,
    output logic            zero
);

    always_comb begin
        case (op)
            OP_CLR_ACC: result = ZERO_BYTE;
            OP_DEC_SKZ: result = mem - ONE_BYTE;
            OP_INC_SKZ: result = mem + ONE_BYTE;
            OP_INC_MEM: result = mem + ONE_BYTE;
            OP_OR_LIT:  result = acc | lit;
            OP_OR_MEM:  result = acc | mem;
            default:    result = ZERO_BYTE;
        endcase
        zero = (result == ZERO_BYTE); // RULE_10
    end

endmodule

/* core_instr_exec_subset.sv */
// Execute stage for clear, inc/dec skip, jump, increment and OR instructions
// How it works
// RULE_01: Clear accumulator to zero, set zero flag
// RULE_02: Decrement memory; destination bit picks target
// RULE_03: Decrement zero result discards next instruction
// RULE_04: Increment zero result skips, two cycles
// RULE_05: Increment routes result; only plain updates zero
// RULE_06: Jump loads immediate and latch bits six-three
// RULE_07: Jump unconditional, two cycles, flags kept
// RULE_08: OR literal into accumulator, update zero
// RULE_09: OR memory, destination bit, update zero
// RULE_10: Zero flag set exactly when result zero
// RULE_11: Memory address is seven bits wide
`timescale 1ns/1ps
module core_instr_exec_subset
    import core_exec_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       instr_valid,
    input  wire instr_s     instr,
    input  wire logic [6:0] upper_address_latch,
    output logic            instr_ready,
    output logic [7:0]      acc_q,
    output logic            zero_flag_q,
    output logic [14:0]     program_counter_q,
    output logic            pc_load_q,
    output logic            flushed_q
);

    logic [7:0]  mem_q [MEM_DEPTH];
    logic [7:0]  mem_rd;
    logic [7:0]  result;
    logic        res_zero;
    state_e      state_q, state_d;
    logic [7:0]  acc_d;
    logic        zero_flag_d;
    logic [14:0] pc_d;
    logic        pc_load_d;
    logic        flushed_d;
    logic        mem_we;
    logic        exec;

    // Sequential advance, shared by executed and discarded slots
    function automatic logic [14:0] pc_step(input logic [14:0] pc);
        return pc + 15'h0001;
    endfunction

    assign mem_rd = mem_q[instr.addr]; // RULE_11
    assign exec   = instr_valid && (state_q == ST_EXEC);
    // Discarded slot still consumes the fetched word
    assign instr_ready = 1'b1;

    core_alu core_alu_i (
        .op     (instr.op),
        .acc    (acc_q),
        .mem    (mem_rd),
        .lit    (instr.imm[7:0]),
        .result (result),
        .zero   (res_zero)
    );

    always_comb begin
        state_d     = state_q;
        acc_d       = acc_q;
        zero_flag_d = zero_flag_q;
        pc_d        = program_counter_q;
        pc_load_d   = 1'b0;
        flushed_d   = 1'b0;
        mem_we      = 1'b0;
        case (state_q)
            ST_EXEC: begin
                if (instr_valid) begin
                    pc_d = pc_step(program_counter_q);
                    case (instr.op)
                        OP_CLR_ACC: begin
                            acc_d       = result; // RULE_01
                            zero_flag_d = 1'b1; // RULE_01
                        end
                        OP_DEC_SKZ, OP_INC_SKZ: begin
                            if (instr.dest_mem) begin
                                mem_we = 1'b1; // RULE_02
                            end else begin
                                acc_d = result; // RULE_05
                            end
                            if (res_zero) begin
                                state_d = ST_FLUSH; // RULE_03 RULE_04
                            end
                        end
                        OP_JUMP: begin
                            // RULE_06
                            pc_d    = {upper_address_latch[LATCH_HI:LATCH_LO], instr.imm};
                            pc_load_d = 1'b1;
                            state_d = ST_FLUSH; // RULE_07
                        end
                        OP_OR_LIT: begin
                            acc_d       = result; // RULE_08
                            zero_flag_d = res_zero; // RULE_10
                        end
                        OP_INC_MEM, OP_OR_MEM: begin
                            if (instr.dest_mem) begin
                                mem_we = 1'b1; // RULE_05 RULE_09
                            end else begin
                                acc_d = result; // RULE_09
                            end
                            zero_flag_d = res_zero; // RULE_10
                        end
                        default: begin
                            acc_d = acc_q;
                        end
                    endcase
                end
            end
            ST_FLUSH: begin
                // Second cycle executes as a no-operation
                if (instr_valid) begin
                    pc_d      = pc_step(program_counter_q);
                    flushed_d = 1'b1; // RULE_03 RULE_04 RULE_07
                    state_d   = ST_EXEC;
                end
            end
            default: state_d = ST_EXEC;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q           <= ST_EXEC;
            acc_q             <= ZERO_BYTE;
            zero_flag_q       <= 1'b0;
            program_counter_q <= PC_RESET;
            pc_load_q         <= 1'b0;
            flushed_q         <= 1'b0;
        end else begin
            state_q           <= state_d;
            acc_q             <= acc_d;
            zero_flag_q       <= zero_flag_d;
            program_counter_q <= pc_d;
            pc_load_q         <= pc_load_d;
            flushed_q         <= flushed_d;
        end
    end

    // Memory has no reset; contents are undefined at power-up
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem_q[instr.addr] <= result;
        end
    end

    clear_sets_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
        exec && instr.op == OP_CLR_ACC |=> acc_q == 8'h00 && zero_flag_q)
        else $error("clear did not zero accumulator and set flag");

    dec_dest_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
        exec && instr.op == OP_DEC_SKZ && !instr.dest_mem |=> acc_q == $past(mem_rd) - 8'h01)
        else $error("decrement result wrong in accumulator");

    skip_on_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
        exec && (instr.op == OP_DEC_SKZ || instr.op == OP_INC_SKZ) && res_zero
        |=> state_q == ST_FLUSH)
        else $error("zero result did not discard next");

    skip_flags_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
        exec && (instr.op == OP_DEC_SKZ || instr.op == OP_INC_SKZ) |=> $stable(zero_flag_q))
        else $error("skip instruction changed zero flag");

    inc_zero_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
        exec && instr.op == OP_INC_MEM |=> zero_flag_q == ($past(mem_rd) == 8'hff))
        else $error("increment zero flag wrong");

    jump_target_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
        exec && instr.op == OP_JUMP
        |=> program_counter_q == {$past(upper_address_latch[6:3]), $past(instr.imm)} && pc_load_q)
        else $error("jump target wrong");

    jump_two_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
        exec && instr.op == OP_JUMP ##1 instr_valid |=> flushed_q && $stable(zero_flag_q))
        else $error("jump did not take two cycles");

    or_literal_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
        exec && instr.op == OP_OR_LIT
        |=> acc_q == ($past(acc_q) | $past(instr.imm[7:0])) && zero_flag_q == (acc_q == 8'h00))
        else $error("or literal wrong");

    or_memory_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
        exec && instr.op == OP_OR_MEM && !instr.dest_mem
        |=> acc_q == ($past(acc_q) | $past(mem_rd)))
        else $error("or memory wrong");

    skip_no_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
        exec && instr.op inside {OP_DEC_SKZ, OP_INC_SKZ} && !res_zero |=> state_q == ST_EXEC)
        else $error("nonzero result discarded next");

    inc_skip_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
        exec && instr.op == OP_INC_SKZ && !instr.dest_mem |=> acc_q == $past(mem_rd) + 8'h01)
        else $error("increment skip result wrong in accumulator");

    inc_skip_two_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
        exec && instr.op == OP_INC_SKZ && res_zero ##1 instr_valid |=> flushed_q)
        else $error("increment skip did not run a no-operation");

    flush_discard_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
        state_q == ST_FLUSH && instr_valid
        |=> flushed_q && !pc_load_q && $stable(acc_q) && $stable(zero_flag_q))
        else $error("discarded slot changed state");

    dest_mem_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
        exec && instr.dest_mem && instr.op inside {OP_DEC_SKZ, OP_INC_SKZ, OP_INC_MEM, OP_OR_MEM}
        |=> $stable(acc_q))
        else $error("memory destination changed accumulator");

    mem_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
        exec && instr.dest_mem && instr.op inside {OP_DEC_SKZ, OP_INC_SKZ, OP_INC_MEM, OP_OR_MEM}
        |=> mem_q[$past(instr.addr)] == $past(result))
        else $error("memory destination not written");

    zero_update_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
        exec && instr.op inside {OP_OR_LIT, OP_OR_MEM, OP_INC_MEM}
        |=> zero_flag_q == ($past(result) == 8'h00))
        else $error("zero flag does not follow result");

    pc_advance_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
        exec && instr.op != OP_JUMP |=> program_counter_q == $past(program_counter_q) + 15'h0001 && !pc_load_q)
        else $error("sequential slot did not advance by one");

endmodule

/* core_instr_exec_subset_tb.sv */
// Self-checking testbench for the execute-stage subset
`timescale 1ns/1ps
module core_instr_exec_subset_tb;
    import core_exec_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n;
    logic        instr_valid;
    instr_s      instr;
    logic [6:0]  upper_address_latch;
    logic        instr_ready;
    logic [7:0]  acc_q;
    logic        zero_flag_q;
    logic [14:0] program_counter_q;
    logic        pc_load_q;
    logic        flushed_q;
    logic [14:0] exp_pc;
    int          miscompares = 0;
    int          num_checks = 0;

    always #4 clk_sys = ~clk_sys;

    core_instr_exec_subset core_instr_exec_subset_i (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .instr_valid        (instr_valid),
        .instr              (instr),
        .upper_address_latch(upper_address_latch),
        .instr_ready        (instr_ready),
        .acc_q              (acc_q),
        .zero_flag_q        (zero_flag_q),
        .program_counter_q  (program_counter_q),
        .pc_load_q          (pc_load_q),
        .flushed_q          (flushed_q)
    );

    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Valid stays high between steps, so no strobe is set twice in one time step
    task automatic step(input op_e op, input logic [6:0] a, input logic d, input logic [10:0] imm,
                        input logic fl, input logic [7:0] acc_e, input logic z_e);
        instr_valid = 1'b1;
        instr = '{op: op, addr: a, dest_mem: d, imm: imm};
        @(posedge clk_sys);
        #1;
        exp_pc = (op == OP_JUMP && !fl) ? {upper_address_latch[6:3], imm} : exp_pc + 15'h0001;
        chk({14'h0000, instr_ready}, 15'h0001);
        chk(program_counter_q, exp_pc);
        chk({14'h0000, pc_load_q}, {14'h0000, op == OP_JUMP && !fl});
        chk({14'h0000, flushed_q}, {14'h0000, fl});
        chk({7'h00, acc_q}, {7'h00, acc_e});
        chk({14'h0000, zero_flag_q}, {14'h0000, z_e});
    endtask

    task automatic t_or_clear;
        step(OP_OR_LIT, '0, 1'b0, 11'h05A, 1'b0, 8'h5A, 1'b0);
        step(OP_OR_LIT, '0, 1'b0, 11'h781, 1'b0, 8'hDB, 1'b0);
        step(OP_CLR_ACC, '0, 1'b0, '0, 1'b0, 8'h00, 1'b1);
        step(OP_NONE, '0, 1'b0, '0, 1'b0, 8'h00, 1'b1);
    endtask

    // Memory starts unknown, so it is forced to all ones through an OR first
    task automatic t_inc;
        step(OP_OR_LIT, '0, 1'b0, 11'h0FF, 1'b0, 8'hFF, 1'b0);
        step(OP_OR_MEM, 7'h7F, 1'b1, '0, 1'b0, 8'hFF, 1'b0);
        step(OP_INC_MEM, 7'h7F, 1'b0, '0, 1'b0, 8'h00, 1'b1);
        step(OP_INC_MEM, 7'h7F, 1'b1, '0, 1'b0, 8'h00, 1'b1);
        step(OP_OR_LIT, '0, 1'b0, 11'h010, 1'b0, 8'h10, 1'b0);
        step(OP_OR_MEM, 7'h7F, 1'b0, '0, 1'b0, 8'h10, 1'b0);
    endtask

    task automatic t_skip;
        step(OP_INC_SKZ, 7'h7F, 1'b1, '0, 1'b0, 8'h10, 1'b0);
        step(OP_CLR_ACC, '0, 1'b0, '0, 1'b0, 8'h00, 1'b1);
        step(OP_OR_LIT, '0, 1'b0, 11'h001, 1'b0, 8'h01, 1'b0);
        step(OP_DEC_SKZ, 7'h7F, 1'b0, '0, 1'b0, 8'h00, 1'b0);
        step(OP_OR_LIT, '0, 1'b0, 11'h080, 1'b1, 8'h00, 1'b0);
        step(OP_DEC_SKZ, 7'h7F, 1'b1, '0, 1'b0, 8'h00, 1'b0);
        step(OP_CLR_ACC, '0, 1'b0, '0, 1'b1, 8'h00, 1'b0);
        step(OP_OR_LIT, '0, 1'b0, 11'h0FF, 1'b0, 8'hFF, 1'b0);
        step(OP_OR_MEM, 7'h7F, 1'b1, '0, 1'b0, 8'hFF, 1'b0);
        step(OP_INC_SKZ, 7'h7F, 1'b0, '0, 1'b0, 8'h00, 1'b0);
        step(OP_OR_LIT, '0, 1'b0, 11'h003, 1'b1, 8'h00, 1'b0);
        step(OP_DEC_SKZ, 7'h7F, 1'b0, '0, 1'b0, 8'hFE, 1'b0);
        step(OP_OR_LIT, '0, 1'b0, 11'h001, 1'b0, 8'hFF, 1'b0);
    endtask

    task automatic t_jump;
        step(OP_JUMP, '0, 1'b0, 11'h5A5, 1'b0, 8'hFF, 1'b0);
        step(OP_CLR_ACC, '0, 1'b0, '0, 1'b1, 8'hFF, 1'b0);
        step(OP_JUMP, '0, 1'b0, 11'h7FF, 1'b0, 8'hFF, 1'b0);
        step(OP_JUMP, '0, 1'b0, 11'h000, 1'b1, 8'hFF, 1'b0);
        instr_valid = 1'b0;
        @(posedge clk_sys);
        #1;
        chk(program_counter_q, exp_pc);
        chk({14'h0000, flushed_q}, 15'h0000);
    endtask

    // Reset in the middle of a skip must leave the next slot executing
    task automatic t_reset;
        step(OP_INC_SKZ, 7'h7F, 1'b0, '0, 1'b0, 8'h00, 1'b0);
        instr_valid = 1'b0;
        rst_n = 1'b0;
        @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        exp_pc = PC_RESET;
        chk({7'h00, acc_q}, {7'h00, ZERO_BYTE});
        chk(program_counter_q, exp_pc);
        chk({14'h0000, flushed_q}, 15'h0000);
        chk({14'h0000, zero_flag_q}, 15'h0000);
        step(OP_OR_LIT, '0, 1'b0, 11'h033, 1'b0, 8'h33, 1'b0);
        step(OP_DEC_SKZ, 7'h7F, 1'b1, '0, 1'b0, 8'h33, 1'b0);
        step(OP_CLR_ACC, '0, 1'b0, '0, 1'b0, 8'h00, 1'b1);
        step(OP_INC_MEM, 7'h7F, 1'b0, '0, 1'b0, 8'hFF, 1'b0);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        upper_address_latch = 7'h55;
        exp_pc = 15'h0000;
        repeat (4) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        chk({7'h00, acc_q}, 15'h0000);
        chk(program_counter_q, 15'h0000);
        t_or_clear();
        t_inc();
        t_skip();
        t_jump();
        t_reset();
        tally_and_finish();
    end

    // About forty clock cycles are needed, so this span leaves a wide margin
    initial begin
        repeat (2000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
endmodule
